// ---- src/xtrap_exec.sv ----
`timescale 1ns/1ps
module xtrap_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output xtrap_pkg::mem_req_type mem_req,
  input wire xtrap_pkg::mem_rsp_type mem_rsp,
  output logic bus_hold
);
  import xtrap_pkg::*;

  // Control register bits: [0] go (self-clearing), [4:1] flags NZCV
  logic [31:0] instr_ff, pc_ff, status_ff, saved_status_supervisor_ff, supervisor_link_reg_ff;
  logic [31:0] result_ff, mstart_ff, mend_ff, base_ff, src_ff;
  logic [7:0] cycles_ff;
  logic [3:0] flags_ff, cond, w_strb_ff;
  logic busy_ff, trap_und_ff, trap_abt_ff, fault_seen_ff, go_ff, bus_hold_ff, cond_ok;
  state_type state_ff;
  class_type cls;
  logic fn, fz, fc, fv;
  mem_req_type mem_req_ff;

  // Write channel: address and data may arrive in either order
  logic aw_got_ff, w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic awready_ff, wready_ff, bvalid_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_write;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign mem_req = mem_req_ff;
  assign bus_hold = bus_hold_ff;

  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      awready_ff <= !aw_got_ff;
      wready_ff <= !w_got_ff;
      if (s_axi_awvalid && awready_ff)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_ff <= 1'b1;
        if (aw_addr_ff == 8'(ADDR_OFF_CTRL) || aw_addr_ff == 8'(ADDR_OFF_INSTR) ||
            aw_addr_ff == 8'(ADDR_OFF_BASE) || aw_addr_ff == 8'(ADDR_OFF_SRC) ||
            aw_addr_ff == 8'(ADDR_OFF_PC))
          bresp_ff <= RESP_OKAY;
        else
          bresp_ff <= RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Writes while busy are dropped so the running instruction sees stable operands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_ff <= 32'h0000_0000;
      base_ff <= 32'h0000_0000;
      src_ff <= 32'h0000_0000;
      flags_ff <= 4'h0;
      go_ff <= 1'b0;
    end
    else
    begin
      go_ff <= 1'b0;
      if (do_write && !busy_ff && w_strb_ff == 4'hf)
      begin
        if (aw_addr_ff == 8'(ADDR_OFF_CTRL))
        begin
          go_ff <= w_data_ff[0];
          flags_ff <= w_data_ff[4:1];
        end
        else if (aw_addr_ff == 8'(ADDR_OFF_INSTR))
          instr_ff <= w_data_ff;
        else if (aw_addr_ff == 8'(ADDR_OFF_BASE))
          base_ff <= w_data_ff;
        else if (aw_addr_ff == 8'(ADDR_OFF_SRC))
          src_ff <= w_data_ff;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= !rvalid_ff && !(s_axi_arvalid && arready_ff);
      if (s_axi_arvalid && arready_ff)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        if (s_axi_araddr == 8'(ADDR_OFF_CTRL))
          rdata_ff <= {24'h0, fault_seen_ff, trap_abt_ff, trap_und_ff, flags_ff, busy_ff};
        else if (s_axi_araddr == 8'(ADDR_OFF_INSTR))
          rdata_ff <= instr_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_PC))
          rdata_ff <= pc_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_STATUS))
          rdata_ff <= status_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_SAVED))
          rdata_ff <= saved_status_supervisor_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_LINK))
          rdata_ff <= supervisor_link_reg_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_RESULT))
          rdata_ff <= result_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_MSTART))
          rdata_ff <= mstart_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_MEND))
          rdata_ff <= mend_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_CYCLES))
          rdata_ff <= {24'h0, cycles_ff};
        else if (s_axi_araddr == 8'(ADDR_OFF_BASE))
          rdata_ff <= base_ff;
        else if (s_axi_araddr == 8'(ADDR_OFF_SRC))
          rdata_ff <= src_ff;
        else
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // Condition evaluation
  assign cond = instr_ff[COND_HI:COND_LO]; // RQ22
  assign {fn, fz, fc, fv} = flags_ff;
  always_comb
  begin
    case (cond)
      4'h0: cond_ok = fz;
      4'h1: cond_ok = !fz;
      4'h2: cond_ok = fc;
      4'h3: cond_ok = !fc;
      4'h4: cond_ok = fn;
      4'h5: cond_ok = !fn;
      4'h6: cond_ok = fv;
      4'h7: cond_ok = !fv;
      4'h8: cond_ok = fc && !fz;
      4'h9: cond_ok = !fc || fz;
      4'ha: cond_ok = fn == fv;
      4'hb: cond_ok = fn != fv;
      4'hc: cond_ok = !fz && (fn == fv);
      4'hd: cond_ok = fz || (fn != fv);
      4'he: cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  end

  // Class decode; coprocessor op looks only at bits 27:24 and 4
  always_comb
  begin
    if (instr_ff[27:24] == 4'hf)
      cls = CLS_SVC; // RQ14
    else if (instr_ff[27:24] == 4'he && !instr_ff[4])
      cls = CLS_COPROC; // RQ18
    else if (instr_ff[27:25] == 3'b110 || (instr_ff[27:24] == 4'he && instr_ff[4]))
      cls = CLS_COPROC; // RQ17
    else if (instr_ff[27:23] == 5'b00010 && instr_ff[21:20] == 2'b00 &&
             instr_ff[11:4] == 8'h09)
      cls = CLS_XCHG;
    else if (instr_ff[27:25] == 3'b100)
      cls = CLS_MULTI;
    else
      cls = CLS_NONE;
  end

  // Multi transfer span: count registers, lowest register at lowest address
  logic [4:0] nregs;
  logic [31:0] span;
  logic pre_b, up_b;
  always_comb
  begin
    nregs = 5'd0;
    for (int i = 0; i < 16; i++)
      nregs = nregs + 5'(instr_ff[i]);
    span = {25'h0, nregs, 2'b00};
    pre_b = instr_ff[24]; // RQ1 RQ3
    up_b = instr_ff[23]; // RQ2 RQ3
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      pc_ff <= 32'h0000_0000;
      status_ff <= STATUS_RESET;
      saved_status_supervisor_ff <= 32'h0000_0000;
      supervisor_link_reg_ff <= 32'h0000_0000;
      result_ff <= 32'h0000_0000;
      mstart_ff <= 32'h0000_0000;
      mend_ff <= 32'h0000_0000;
      cycles_ff <= 8'h00;
      trap_und_ff <= 1'b0;
      trap_abt_ff <= 1'b0;
      fault_seen_ff <= 1'b0;
      mem_req_ff <= '0;
      bus_hold_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (go_ff)
          begin
            busy_ff <= 1'b1;
            trap_und_ff <= 1'b0;
            trap_abt_ff <= 1'b0;
            fault_seen_ff <= 1'b0;
            cycles_ff <= 8'h00;
            state_ff <= ST_DECODE;
          end
        end
        ST_DECODE:
        begin
          if (!cond_ok)
          begin
            pc_ff <= pc_ff + PC_NEXT; // RQ20 RQ23
            state_ff <= ST_DONE;
          end
          else if (cls == CLS_XCHG)
          begin
            mem_req_ff.req <= 1'b1; // RQ4 RQ5
            mem_req_ff.wr <= 1'b0;
            mem_req_ff.byte_sel <= instr_ff[22]; // RQ9
            mem_req_ff.addr <= base_ff;
            bus_hold_ff <= 1'b1; // RQ7
            cycles_ff <= cycles_ff + 8'h01;
            state_ff <= ST_XRD;
          end
          else if (cls == CLS_SVC)
          begin
            saved_status_supervisor_ff <= status_ff; // RQ12
            status_ff <= {status_ff[31:8], 1'b1, status_ff[6:5], MODE_SVC};
            supervisor_link_reg_ff <= pc_ff + PC_NEXT; // RQ13
            pc_ff <= SVC_VECTOR;
            cycles_ff <= 8'h03; // RQ15
            state_ff <= ST_DONE;
          end
          else if (cls == CLS_COPROC)
          begin
            // No coprocessor ever answers, so nothing is awaited
            state_ff <= ST_TRAP; // RQ16 RQ17
            trap_und_ff <= 1'b1;
          end
          else
          begin
            if (cls == CLS_MULTI)
            begin
              // Lowest transfer address and base moved by the span, ascending register order
              if (up_b)
              begin
                mstart_ff <= pre_b ? base_ff + WORD_STEP : base_ff; // RQ21
                mend_ff <= base_ff + span;
              end
              else
              begin
                mstart_ff <= pre_b ? base_ff - span : base_ff - span + WORD_STEP;
                mend_ff <= base_ff - span;
              end
            end
            pc_ff <= pc_ff + PC_NEXT;
            state_ff <= ST_DONE;
          end
        end
        ST_XRD:
        begin
          if (mem_rsp.done)
          begin
            fault_seen_ff <= fault_seen_ff | mem_rsp.fault; // RQ10
            result_ff <= instr_ff[22] ? (mem_rsp.rdata & BYTE_MASK) : mem_rsp.rdata;
            mem_req_ff.wr <= 1'b1;
            mem_req_ff.wdata <= instr_ff[22] ? (src_ff & BYTE_MASK) : src_ff; // RQ6
            cycles_ff <= cycles_ff + 8'h01;
            state_ff <= ST_XWR;
          end
        end
        ST_XWR:
        begin
          if (mem_rsp.done)
          begin
            fault_seen_ff <= fault_seen_ff | mem_rsp.fault; // RQ10
            mem_req_ff.req <= 1'b0;
            mem_req_ff.wr <= 1'b0;
            bus_hold_ff <= 1'b0; // RQ7 RQ8
            cycles_ff <= cycles_ff + 8'h01;
            state_ff <= ST_XINT;
          end
        end
        ST_XINT:
        begin
          cycles_ff <= cycles_ff + 8'h01; // RQ11
          if (fault_seen_ff)
          begin
            trap_abt_ff <= 1'b1;
            state_ff <= ST_TRAP;
          end
          else
          begin
            pc_ff <= pc_ff + PC_NEXT;
            state_ff <= ST_DONE;
          end
        end
        ST_TRAP:
        begin
          status_ff <= {status_ff[31:8], 1'b1, status_ff[6:5],
                        trap_abt_ff ? MODE_ABT : MODE_UND};
          pc_ff <= trap_abt_ff ? ABORT_VECTOR : UNDEF_VECTOR;
          state_ff <= ST_DONE;
        end
        ST_DONE:
        begin
          busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // xtrap_exec

// ---- src/xtrap_pkg.sv ----
// Operation
// RQ1 - Full-stack names adjust address before each store; empty-stack names adjust after.
// RQ2 - Ascending: stores increment, loads decrement; descending does the reverse.
// RQ3 - Non-stack names select increment/decrement after/before stepping.
// RQ4 - Exchange is one read then one write, locked, no interrupt between.
// RQ5 - Exchange reads base address, writes source there, old value to destination.
// RQ6 - Exchange works when source and destination registers coincide.
// RQ7 - Bus-hold output high across exchange read and write, low otherwise.
// RQ8 - Memory manager never takes the bus while bus-hold is high.
// RQ9 - Byte-select bit set means byte transfer, clear means word.
// RQ10 - Fault on exchange read, write or both takes data abort trap.
// RQ11 - Exchange costs one sequential, two non-sequential, one internal cycle.
// RQ12 - Supervisor call enters supervisor mode, vector 0x08, saves status word.
// RQ13 - Supervisor call writes next instruction address into supervisor link register.
// RQ14 - Low 24 bits of supervisor call are ignored.
// RQ15 - Supervisor call costs two sequential and one non-sequential cycle.
// RQ16 - Coprocessor operation expects no result and does not wait.
// RQ17 - Every coprocessor instruction takes the undefined instruction trap.
// RQ18 - Coprocessor operations decode only bit 4 and bits 31 to 24.
// RQ19 - Coprocessor responds only to its own number in the number field.
// RQ20 - Each instruction executes only when its condition passes.
// RQ21 - Multi transfers go in ascending register order, lowest at lowest address.
// RQ22 - Condition code comes from instruction bits 31 to 28.
// RQ23 - Failed condition changes nothing and raises no trap.
package xtrap_pkg;

  localparam logic [31:0] SVC_VECTOR = 32'h0000_0008;
  localparam logic [31:0] UNDEF_VECTOR = 32'h0000_0004;
  localparam logic [31:0] ABORT_VECTOR = 32'h0000_0010;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int IRQ_MASK_BIT = 7;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_NEXT = 32'h0000_0004;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
  localparam int ADDR_OFF_CTRL = 'h00;
  localparam int ADDR_OFF_INSTR = 'h04;
  localparam int ADDR_OFF_PC = 'h08;
  localparam int ADDR_OFF_STATUS = 'h0c;
  localparam int ADDR_OFF_SAVED = 'h10;
  localparam int ADDR_OFF_LINK = 'h14;
  localparam int ADDR_OFF_RESULT = 'h18;
  localparam int ADDR_OFF_MSTART = 'h1c;
  localparam int ADDR_OFF_MEND = 'h20;
  localparam int ADDR_OFF_CYCLES = 'h24;
  localparam int ADDR_OFF_BASE = 'h28;
  localparam int ADDR_OFF_SRC = 'h2c;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DECODE = 4'b0001,
    ST_XRD = 4'b0011,
    ST_XWR = 4'b0010,
    ST_XINT = 4'b0110,
    ST_TRAP = 4'b0111,
    ST_DONE = 4'b0101
  } state_type;

  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_MULTI = 3'h1,
    CLS_XCHG = 3'h2,
    CLS_SVC = 3'h3,
    CLS_COPROC = 3'h4
  } class_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic byte_sel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic done;
    logic fault;
    logic [31:0] rdata;
  } mem_rsp_type;

endpackage

// ---- test/xtrap_exec_checker.sv ----
`timescale 1ns/1ps
module xtrap_exec_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire xtrap_pkg::mem_req_type mem_req,
  input wire xtrap_pkg::mem_rsp_type mem_rsp,
  input wire logic bus_hold
);
  import xtrap_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = mem_req.req && !mem_req.wr && mem_rsp.done;
  assign wr_ok = mem_req.req && mem_req.wr && mem_rsp.done;
  a_lock_covers_req: assert property (mem_req.req |-> bus_hold)
    else $error("access without bus hold");
  a_read_then_write: assert property (rd_ok |=> mem_req.req && mem_req.wr)
    else $error("read not followed by write");
  a_same_address: assert property (rd_ok |=> mem_req.addr == $past(mem_req.addr))
    else $error("write address differs from read");
  a_lock_release: assert property (wr_ok |=> !bus_hold && !mem_req.req)
    else $error("bus hold kept after write");
  a_lock_start: assert property ($rose(bus_hold) |-> mem_req.req && !mem_req.wr)
    else $error("hold raised without read");
  a_byte_steady: assert property (rd_ok |=> mem_req.byte_sel == $past(mem_req.byte_sel))
    else $error("size changed within exchange");
  a_req_waits: assert property (mem_req.req && !mem_rsp.done |=> mem_req.req
    && $stable(mem_req.wr) && $stable(mem_req.addr))
    else $error("access withdrawn before done");
  a_lock_no_gap: assert property (bus_hold && !wr_ok |=> bus_hold)
    else $error("bus hold dropped early");
  c_read_done: cover property (rd_ok);
  c_write_fault: cover property (wr_ok && mem_rsp.fault);
  c_byte_access: cover property (mem_req.req && mem_req.byte_sel);
endmodule // xtrap_exec_checker

bind xtrap_exec xtrap_exec_checker u_xtrap_exec_checker (.aclk(aclk), .aresetn(aresetn),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .bus_hold(bus_hold));

// ---- test/xtrap_mem_model.sv ----
`timescale 1ns/1ps
module xtrap_mem_model #(
  parameter logic [31:0] INIT_WORD = 32'h1357_9bdf
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire xtrap_pkg::mem_req_type mem_req,
  output xtrap_pkg::mem_rsp_type mem_rsp,
  input wire logic [3:0] delay,
  input wire logic fault_rd,
  input wire logic fault_wr,
  output logic [31:0] mem_word,
  output logic [7:0] rd_cnt,
  output logic [7:0] wr_cnt
);
  import xtrap_pkg::*;
  logic [3:0] wait_ff;
  logic hit;
  assign hit = mem_req.req && !mem_rsp.done && wait_ff >= delay;
  // Always answers in time; never takes the bus away mid exchange
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_ff <= 4'h0;
      mem_rsp <= '0;
    end
    else
    begin
      wait_ff <= (mem_req.req && !hit && !mem_rsp.done) ? wait_ff + 4'h1 : 4'h0;
      mem_rsp.done <= hit;
      mem_rsp.fault <= hit && (mem_req.wr ? fault_wr : fault_rd);
      // Idle data toggles so a stale value is never mistaken for a read
      mem_rsp.rdata <= (hit && !mem_req.wr) ? mem_word : ~mem_rsp.rdata;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_word <= INIT_WORD;
      rd_cnt <= 8'h00;
      wr_cnt <= 8'h00;
    end
    else if (hit && mem_req.wr)
    begin
      wr_cnt <= wr_cnt + 8'h01;
      if (!fault_wr)
        mem_word <= mem_req.byte_sel ? {mem_word[31:8], mem_req.wdata[7:0]} : mem_req.wdata;
    end
    else if (hit)
      rd_cnt <= rd_cnt + 8'h01;
  end
endmodule // xtrap_mem_model

// ---- test/tb_xtrap_exec.sv ----
`timescale 1ns/1ps
module tb_xtrap_exec;
  import xtrap_pkg::*;
  localparam logic [31:0] MEM_INIT = 32'h1357_9bdf;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rd_cnt, wr_cnt, n_rd;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_word, rd, st, pcv, exp_mem;
  logic [3:0] s_axi_wstrb, delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic bus_hold, fault_rd, fault_wr;
  mem_req_type mem_req;
  mem_rsp_type mem_rsp;
  int n_fail, n_compared;
  logic [31:0] rows [8][2];

  xtrap_exec u_xtrap_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .mem_req(mem_req), .mem_rsp(mem_rsp), .bus_hold(bus_hold));
  xtrap_mem_model #(.INIT_WORD(MEM_INIT)) u_xtrap_mem_model (.aclk(aclk), .aresetn(aresetn),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .delay(delay), .fault_rd(fault_rd),
    .fault_wr(fault_wr), .mem_word(mem_word), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input int a, input logic [31:0] d);
    logic aw_d, w_d;
    @(posedge aclk);
    s_axi_awaddr <= a[7:0];
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    // Address and data may be taken on different edges
    while (!(aw_d && w_d))
    begin
      @(posedge aclk);
      if (s_axi_awready && !aw_d)
      begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_d)
      begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input int a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a[7:0];
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic run(input logic [31:0] instr, input logic [3:0] nzcv);
    axi_wr(ADDR_OFF_INSTR, instr);
    axi_wr(ADDR_OFF_CTRL, {27'h0, nzcv, 1'b1});
    do axi_rd(ADDR_OFF_CTRL, rd, rsp); while (rd[0] !== 1'b0);
  endtask

  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {aresetn, fault_rd, fault_wr, delay} = 7'h00;
    n_fail = 0;
    n_compared = 0;
    exp_mem = MEM_INIT;
    // Rows: instruction, lowest transfer address for base 0x1000 and registers 1, 5, 7
    rows = '{'{32'he800_00a2, 32'h0000_0ff8}, '{32'he810_00a2, 32'h0000_0ff8},
      '{32'he880_00a2, 32'h0000_1000}, '{32'he890_00a2, 32'h0000_1000},
      '{32'he900_00a2, 32'h0000_0ff4}, '{32'he910_00a2, 32'h0000_0ff4},
      '{32'he980_00a2, 32'h0000_1004}, '{32'he990_00a2, 32'h0000_1004}};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_OFF_STATUS, rd, rsp);
    chk_word(rd, STATUS_RESET);
    axi_rd(8'h80, rd, rsp);
    chk_word({rd[31:2], rd[1:0] | rsp}, {30'h0, RESP_SLVERR});
    axi_wr(ADDR_OFF_STATUS, 32'h0000_0000);
    chk_word({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(ADDR_OFF_BASE, 32'h0000_1000);
    chk_word({30'h0, rsp}, {30'h0, RESP_OKAY});
    for (int i = 0; i < 8; i++)
    begin
      run(rows[i][0], 4'h0);
      axi_rd(ADDR_OFF_MSTART, rd, rsp);
      chk_word(rd, rows[i][1]);
    end
    axi_wr(ADDR_OFF_BASE, 32'h0000_0200);
    axi_wr(ADDR_OFF_SRC, 32'ha5a5_1234);
    // Partial strobes must leave the source word alone
    s_axi_wstrb <= 4'h3;
    axi_wr(ADDR_OFF_SRC, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    delay <= 4'h2;
    run(32'he100_0091, 4'h0);
    axi_rd(ADDR_OFF_RESULT, rd, rsp);
    chk_word(rd, exp_mem);
    exp_mem = 32'ha5a5_1234;
    chk_word(mem_word, exp_mem);
    axi_rd(ADDR_OFF_CYCLES, rd, rsp);
    chk_word(rd, 32'h4);
    axi_rd(ADDR_OFF_CTRL, rd, rsp);
    chk_word({30'h0, rd[6:5]}, 32'h0);
    axi_wr(ADDR_OFF_SRC, 32'h1111_11c3);
    run(32'he100_0090, 4'h0);
    axi_rd(ADDR_OFF_RESULT, rd, rsp);
    chk_word(rd, exp_mem);
    exp_mem = 32'h1111_11c3;
    axi_wr(ADDR_OFF_SRC, 32'h2222_225a);
    run(32'he140_0091, 4'h0);
    axi_rd(ADDR_OFF_RESULT, rd, rsp);
    chk_word(rd, exp_mem & BYTE_MASK);
    chk_word(mem_word, 32'h1111_115a);
    n_rd = rd_cnt;
    axi_rd(ADDR_OFF_LINK, st, rsp);
    run(32'h0100_0091, 4'b0000);
    run(32'h1f00_0000, 4'b0100);
    chk_word({24'h0, rd_cnt}, {24'h0, n_rd});
    axi_rd(ADDR_OFF_LINK, rd, rsp);
    chk_word(rd, st);
    run(32'h0100_0091, 4'b0100);
    chk_word({24'h0, rd_cnt}, {24'h0, n_rd + 8'h01});
    for (int i = 0; i < 2; i++)
    begin
      axi_rd(ADDR_OFF_STATUS, st, rsp);
      axi_rd(ADDR_OFF_PC, pcv, rsp);
      run(i ? 32'hefff_ffff : 32'hef00_0000, 4'h0);
      axi_rd(ADDR_OFF_PC, rd, rsp);
      chk_word(rd, SVC_VECTOR);
      axi_rd(ADDR_OFF_LINK, rd, rsp);
      chk_word(rd, pcv + PC_NEXT);
      axi_rd(ADDR_OFF_SAVED, rd, rsp);
      chk_word(rd, st);
      axi_rd(ADDR_OFF_STATUS, rd, rsp);
      chk_word({27'h0, rd[4:0]}, {27'h0, MODE_SVC});
      axi_rd(ADDR_OFF_CYCLES, rd, rsp);
      chk_word(rd, 32'h3);
    end
    n_rd = rd_cnt;
    for (int cp = 0; cp < 16; cp++)
    begin
      run(32'hee12_3006 | (cp << 8) | (cp[0] ? 32'h10 : 32'h0), 4'h0);
      axi_rd(ADDR_OFF_PC, rd, rsp);
      chk_word(rd, UNDEF_VECTOR);
      axi_rd(ADDR_OFF_CTRL, rd, rsp);
      chk_word({31'h0, rd[5]}, 32'h1);
    end
    chk_word({24'h0, rd_cnt}, {24'h0, n_rd});
    for (int f = 1; f < 4; f++)
    begin
      fault_rd <= f[0];
      fault_wr <= f[1];
      delay <= f[3:0];
      run(32'he100_0091, 4'h0);
      axi_rd(ADDR_OFF_PC, rd, rsp);
      chk_word(rd, ABORT_VECTOR);
      axi_rd(ADDR_OFF_CTRL, rd, rsp);
      chk_word({31'h0, rd[6]}, 32'h1);
    end
    fault_rd <= 1'b0;
    fault_wr <= 1'b0;
    axi_wr(ADDR_OFF_INSTR, 32'he100_0091);
    axi_wr(ADDR_OFF_CTRL, 32'h1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_word({31'h0, bus_hold}, 32'h0);
    axi_rd(ADDR_OFF_STATUS, rd, rsp);
    chk_word(rd, STATUS_RESET);
    stop_test();
  end
endmodule // tb_xtrap_exec
